// ### design/rvfcp_crc16.sv
/*
 * One byte step of the CSI-2 payload checksum, purely combinational.
 * Assumes bytes are fed least significant bit first, as on the lanes.
 */
`timescale 1ns/100ps
module rvfcp_crc16 (
	input wire logic [15:0] crc_in,
	input wire logic [7:0] data,
	output logic [15:0] crc_out
);
	import rvfcp_pkg::*;

	logic [15:0] c;

	always_comb
	begin
		c = crc_in ^ {8'h00, data};
		for (int i = 0; i < 8; i++)
		begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
		end
		crc_out = c;
	end

endmodule : rvfcp_crc16

// ### design/rvfcp_pkg.sv
/*
 * Constants and types shared by the raw video framer and CSI-2 packetizer.
 * Assumes it is compiled before every other file of the block.
 */
package rvfcp_pkg;

	// ************************************************************
	// Register map (registers sit outside, contents arrive on ports)
	// ************************************************************
	localparam logic [7:0] SYNC_POL_CFG_OFFSET = 8'h7c;
	localparam logic [7:0] MIN_FRAME_SETUP_OFFSET = 8'hbc;
	localparam logic [7:0] MIN_FRAME_SETUP_RESET = 8'h80;
	localparam int POL_BITS_PER_PORT = 2;
	localparam int FV_POL_BIT = 0;
	localparam int LV_POL_BIT = 1;

	// ************************************************************
	// CSI-2 packet constants
	// ************************************************************
	localparam logic [5:0] DT_FRAME_START = 6'h00;
	localparam logic [5:0] DT_FRAME_END = 6'h01;
	localparam logic [5:0] DT_LINE_START = 6'h02;
	localparam logic [5:0] DT_LINE_END = 6'h03;
	localparam logic [5:0] DT_SHORT_LAST = 6'h0f;
	localparam int ECC_BITS = 6;
	// Parity masks over {word count, data identifier}, index 0 is parity bit 0
	localparam logic [5:0][23:0] ECC_MASKS = {24'heffc00, 24'hdf03f0, 24'hb8e38e,
		24'h749a6d, 24'hf2555b, 24'hf12cb7};
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
	localparam logic [1:0] HDR_LAST_IDX = 2'h3;
	localparam logic [1:0] CRC_LAST_IDX = 2'h1;

	// ************************************************************
	// Line buffer
	// ************************************************************
	localparam int LINE_ADDR_W = 12;
	localparam logic [12:0] LINE_MAX_LEN = 13'h1000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SHORT = 3'b001,
		ST_LHDR = 3'b010,
		ST_PAY = 3'b011,
		ST_CRC = 3'b100
	} rvfcp_tx_state_t;

endpackage : rvfcp_pkg

// ### design/rvfcp_top.sv
/*
 * Raw-mode frame/line recovery for one receive port and CSI-2 packet build.
 * Assumes frame/line indicators and pixel bytes arrive synchronous to LINK_CLK,
 * configuration comes quasi-static from CLK-domain registers, and LINK_CLK is
 * at least four CLK periods long.
 */
`timescale 1ns/100ps

// Functional notes
// - Derive frame and line valid per port
// - Frame valid is vsync, line valid hsync
// - Per-port independent polarity for both indicators
// - Frame valid must precede first line minimum
// - Drop short-setup first line unless kept
// - Emit short and long packets
// - Payload carried as untouched bytes
// - Up to four virtual channels
// - Frame and line start/end packets
// - Data types 0x00-0x0F are 32-bit short
// - Long packet is header, payload, footer
// - Header is identifier, word count, ECC
// - Identifier holds channel and data type
// - Word count equals payload bytes
// - Header ECC corrects one, detects two
// - Sixteen-bit CRC over payload appended
// - Any byte value is legal payload
// - Channel in top two identifier bits
// - Recovered syncs build outgoing packets
module rvfcp_top #(
	parameter int PORT_ID = 0
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic LINK_CLK,
	input wire logic FRAME_VALID_IND,
	input wire logic LINE_VALID_IND,
	input wire logic [7:0] PIXEL_DATA,
	input wire logic [7:0] SYNC_POLARITY_CFG,
	input wire logic [7:0] MIN_FRAME_SETUP_TIME,
	input wire logic KEEP_SHORT_FIRST_LINE,
	input wire logic [1:0] VIRTUAL_CHANNEL,
	input wire logic [5:0] LONG_DATA_TYPE,
	output logic [7:0] TX_DATA,
	output logic TX_VALID,
	output logic TX_PKT_START,
	output logic TX_PKT_END
);
	import rvfcp_pkg::*;

	localparam int FV_IDX = PORT_ID * POL_BITS_PER_PORT + FV_POL_BIT;
	localparam int LV_IDX = PORT_ID * POL_BITS_PER_PORT + LV_POL_BIT;
	localparam logic [10:0] LINK_CFG_RESET = {1'b0, MIN_FRAME_SETUP_RESET, 2'b00};

	function automatic logic [7:0] rvfcp_ecc(input logic [23:0] d);
		logic [7:0] e;
		e = 8'h00;
		for (int i = 0; i < ECC_BITS; i++)
		begin
			e[i] = ^(d & ECC_MASKS[i]);
		end
		return e;
	endfunction : rvfcp_ecc

	// ************************************************************
	// Link domain
	// ************************************************************
	typedef struct packed {
		logic [10:0] cfg_s1;
		logic [10:0] cfg_s2;
		logic fv_d;
		logic lv_d;
		logic [8:0] cnt;
		logic first_seen;
		logic line_ok;
		logic tog;
		logic h_fs;
		logic h_pix;
		logic h_le;
		logic h_fe;
		logic [7:0] h_byte;
	} rvfcp_link_t;

	rvfcp_link_t l_reg;
	rvfcp_link_t l_next;
	logic lrst_s1;
	logic lrst_s2;
	logic fv;
	logic lv;
	logic act;
	logic ev_fs;
	logic ev_fe;
	logic line_start;
	logic first_eff;
	logic [8:0] cnt_eff;
	logic setup_met;
	logic start_ok;
	logic pix;
	logic le;

	// Reset is asserted at once but released on a link edge, so the link
	// logic never leaves reset half-way through a link clock period.
	always_ff @(posedge LINK_CLK or posedge RST)
	begin
		if (RST)
		begin
			lrst_s1 <= 1'b1;
			lrst_s2 <= 1'b1;
		end
		else
		begin
			lrst_s1 <= 1'b0;
			lrst_s2 <= lrst_s1;
		end
	end

	always_comb
	begin
		l_next = l_reg;
		// Configuration is quasi-static; software changes it between frames
		l_next.cfg_s1 = {KEEP_SHORT_FIRST_LINE, MIN_FRAME_SETUP_TIME,
			SYNC_POLARITY_CFG[LV_IDX], SYNC_POLARITY_CFG[FV_IDX]};
		l_next.cfg_s2 = l_reg.cfg_s1;
		fv = FRAME_VALID_IND ^ l_reg.cfg_s2[0];
		lv = LINE_VALID_IND ^ l_reg.cfg_s2[1];
		act = fv & lv;
		ev_fs = fv & ~l_reg.fv_d;
		ev_fe = ~fv & l_reg.fv_d;
		line_start = act & ~l_reg.lv_d;
		first_eff = l_reg.first_seen & ~ev_fs;
		cnt_eff = ev_fs ? 9'h000 : l_reg.cnt;
		setup_met = cnt_eff >= {1'b0, l_reg.cfg_s2[9:2]};
		start_ok = first_eff | setup_met | l_reg.cfg_s2[10];
		pix = act & (line_start ? start_ok : l_reg.line_ok);
		le = l_reg.line_ok & l_reg.lv_d & ~act;
		l_next.fv_d = fv;
		l_next.lv_d = act;
		if (ev_fs)
		begin
			l_next.cnt = 9'h001;
			l_next.first_seen = 1'b0;
		end
		else if (fv && l_reg.cnt != 9'h1ff)
		begin
			l_next.cnt = l_reg.cnt + 9'h001;
		end
		if (line_start)
		begin
			l_next.first_seen = 1'b1;
			l_next.line_ok = start_ok;
		end
		if (le)
		begin
			l_next.line_ok = 1'b0;
		end
		// One event word per link edge; toggling hands it to the CLK side
		if (ev_fs || pix || le || ev_fe)
		begin
			l_next.h_fs = ev_fs;
			l_next.h_pix = pix;
			l_next.h_le = le;
			l_next.h_fe = ev_fe;
			l_next.h_byte = PIXEL_DATA;
			l_next.tog = ~l_reg.tog;
		end
	end

	always_ff @(posedge LINK_CLK or posedge lrst_s2)
	begin
		if (lrst_s2)
		begin
			l_reg <= '{cfg_s1: LINK_CFG_RESET, cfg_s2: LINK_CFG_RESET, default: '0};
		end
		else
		begin
			l_reg <= l_next;
		end
	end

	// ************************************************************
	// Transmit domain
	// ************************************************************
	typedef struct packed {
		logic tog_s1;
		logic tog_s2;
		logic tog_s3;
		logic fs_pend;
		logic fe_pend;
		logic line_pend;
		logic line_bank;
		logic [12:0] line_len;
		logic wbank;
		logic [12:0] waddr;
		rvfcp_tx_state_t state;
		logic [1:0] idx;
		logic [5:0] sdt;
		logic [15:0] crc;
		logic rbank;
		logic [12:0] raddr;
		logic [12:0] rlen;
		logic [1:0] vc;
		logic [5:0] ldt;
		logic [7:0] out_data;
		logic out_valid;
		logic out_start;
		logic out_end;
	} rvfcp_tx_t;

	rvfcp_tx_t r;
	rvfcp_tx_t n;
	logic [7:0] line_mem [2 * (1 << LINE_ADDR_W)];
	logic mem_we;
	logic [LINE_ADDR_W:0] mem_wa;
	logic [7:0] mem_rd;
	logic [15:0] crc_next;
	logic ev;
	logic [23:0] pk_hdr;
	logic [31:0] pk_word;
	logic [12:0] raddr_inc;

	rvfcp_crc16 u_crc (
		.crc_in(r.crc),
		.data(mem_rd),
		.crc_out(crc_next)
	);

	assign mem_rd = line_mem[{r.rbank, r.raddr[LINE_ADDR_W-1:0]}];
	assign mem_wa = {r.wbank, r.waddr[LINE_ADDR_W-1:0]};
	assign raddr_inc = r.raddr + 13'h0001;

	always_comb
	begin
		n = r;
		n.tog_s1 = l_reg.tog;
		n.tog_s2 = r.tog_s1;
		n.tog_s3 = r.tog_s2;
		ev = r.tog_s2 ^ r.tog_s3;
		mem_we = 1'b0;
		if (r.state == ST_LHDR)
		begin
			pk_hdr = {3'b000, r.rlen, r.vc, r.ldt};
		end
		else
		begin
			pk_hdr = {16'h0000, r.vc, r.sdt};
		end
		pk_word = {rvfcp_ecc(pk_hdr), pk_hdr};
		n.out_valid = 1'b0;
		n.out_start = 1'b0;
		n.out_end = 1'b0;
		unique case (r.state)
			ST_IDLE:
			begin
				n.vc = VIRTUAL_CHANNEL;
				n.ldt = LONG_DATA_TYPE;
				n.idx = 2'h0;
				// A pending frame start means the pending line is the new frame's
				if (r.line_pend && !r.fs_pend)
				begin
					n.line_pend = 1'b0;
					n.rbank = r.line_bank;
					n.rlen = r.line_len;
					n.sdt = DT_LINE_START;
					n.state = ST_SHORT;
				end
				else if (r.fe_pend)
				begin
					n.fe_pend = 1'b0;
					n.sdt = DT_FRAME_END;
					n.state = ST_SHORT;
				end
				else if (r.fs_pend)
				begin
					n.fs_pend = 1'b0;
					n.sdt = DT_FRAME_START;
					n.state = ST_SHORT;
				end
			end
			ST_SHORT, ST_LHDR:
			begin
				n.out_data = pk_word[{r.idx, 3'b000} +: 8];
				n.out_valid = 1'b1;
				n.out_start = (r.idx == 2'h0);
				n.out_end = (r.idx == HDR_LAST_IDX) && (r.state == ST_SHORT);
				n.idx = r.idx + 2'h1;
				if (r.idx == HDR_LAST_IDX)
				begin
					n.idx = 2'h0;
					n.raddr = 13'h0000;
					n.crc = CRC_INIT;
					if (r.state == ST_LHDR)
					begin
						n.state = (r.rlen == 13'h0000) ? ST_CRC : ST_PAY;
					end
					else if (r.sdt == DT_LINE_START)
					begin
						n.state = ST_LHDR;
					end
					else
					begin
						n.state = ST_IDLE;
					end
				end
			end
			ST_PAY:
			begin
				n.out_data = mem_rd;
				n.out_valid = 1'b1;
				n.crc = crc_next;
				n.raddr = raddr_inc;
				if (raddr_inc == r.rlen)
				begin
					n.state = ST_CRC;
				end
			end
			ST_CRC:
			begin
				n.out_data = (r.idx == 2'h0) ? r.crc[7:0] : r.crc[15:8];
				n.out_valid = 1'b1;
				n.out_end = (r.idx == CRC_LAST_IDX);
				n.idx = r.idx + 2'h1;
				if (r.idx == CRC_LAST_IDX)
				begin
					n.idx = 2'h0;
					n.sdt = DT_LINE_END;
					n.state = ST_SHORT;
				end
			end
			default:
			begin
				n.state = ST_IDLE;
			end
		endcase
		// Events are applied after the FSM so a new event wins over a clear
		if (ev)
		begin
			if (l_reg.h_fs)
			begin
				n.fs_pend = 1'b1;
			end
			if (l_reg.h_pix && r.waddr < LINE_MAX_LEN)
			begin
				mem_we = 1'b1;
				n.waddr = r.waddr + 13'h0001;
			end
			if (l_reg.h_le)
			begin
				n.line_pend = 1'b1;
				n.line_bank = r.wbank;
				n.line_len = r.waddr;
				n.wbank = ~r.wbank;
				n.waddr = 13'h0000;
			end
			if (l_reg.h_fe)
			begin
				n.fe_pend = 1'b1;
			end
		end
	end

	// Line memory needs no reset; only written bytes are ever read back
	always_ff @(posedge CLK)
	begin
		if (mem_we)
		begin
			line_mem[mem_wa] <= l_reg.h_byte;
		end
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			r <= '{state: ST_IDLE, default: '0};
		end
		else
		begin
			r <= n;
		end
	end

	assign TX_DATA = r.out_data;
	assign TX_VALID = r.out_valid;
	assign TX_PKT_START = r.out_start;
	assign TX_PKT_END = r.out_end;

	// ************************************************************
	// Checks
	// ************************************************************
	logic [16:0] hk_cnt;
	logic [7:0] hk_b0;
	logic [7:0] hk_b1;
	logic [7:0] hk_b2;
	logic hk_long;

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			hk_cnt <= 17'h00000;
			hk_b0 <= 8'h00;
			hk_b1 <= 8'h00;
			hk_b2 <= 8'h00;
			hk_long <= 1'b0;
		end
		else if (TX_PKT_START)
		begin
			hk_cnt <= 17'h00001;
			hk_b0 <= TX_DATA;
			hk_long <= TX_DATA[5:0] > DT_SHORT_LAST;
		end
		else if (TX_VALID)
		begin
			hk_cnt <= hk_cnt + 17'h00001;
			if (hk_cnt == 17'h00001)
			begin
				hk_b1 <= TX_DATA;
			end
			if (hk_cnt == 17'h00002)
			begin
				hk_b2 <= TX_DATA;
			end
		end
	end

	property p_short_len;
		@(posedge CLK) disable iff (RST)
		(TX_PKT_START && TX_DATA[5:0] <= DT_SHORT_LAST) |-> !TX_PKT_END [*3] ##1 TX_PKT_END;
	endproperty
	a_short_len: assert property (p_short_len) else $error("short packet not 4 bytes");

	property p_ecc;
		@(posedge CLK) disable iff (RST)
		(TX_VALID && !TX_PKT_START && hk_cnt == 17'h00003) |->
			TX_DATA == rvfcp_ecc({hk_b2, hk_b1, hk_b0});
	endproperty
	a_ecc: assert property (p_ecc) else $error("header ECC byte wrong");

	property p_pay_len;
		@(posedge CLK) disable iff (RST)
		(TX_PKT_END && !TX_PKT_START && hk_long) |-> hk_cnt == ({1'b0, hk_b2, hk_b1} + 17'h00005);
	endproperty
	a_pay_len: assert property (p_pay_len) else $error("long packet length != WC");

	property p_vc;
		@(posedge CLK) disable iff (RST)
		TX_PKT_START |-> TX_DATA[7:6] == VIRTUAL_CHANNEL;
	endproperty
	a_vc: assert property (p_vc) else $error("virtual channel misplaced");

	property p_le_follow;
		@(posedge CLK) disable iff (RST)
		(TX_PKT_END && !TX_PKT_START && hk_long) |=>
			TX_PKT_START && TX_DATA[5:0] == DT_LINE_END;
	endproperty
	a_le_follow: assert property (p_le_follow) else $error("no line end after line");

	property p_contig;
		@(posedge CLK) disable iff (RST)
		(TX_VALID && !TX_PKT_END) |=> TX_VALID;
	endproperty
	a_contig: assert property (p_contig) else $error("gap inside packet");

	property p_fs_event;
		@(posedge LINK_CLK) disable iff (lrst_s2)
		ev_fs |=> (l_reg.tog != $past(l_reg.tog)) && l_reg.h_fs;
	endproperty
	a_fs_event: assert property (p_fs_event) else $error("frame start not handed over");

	property p_drop_line;
		@(posedge LINK_CLK) disable iff (lrst_s2)
		(line_start && !first_eff && !l_reg.cfg_s2[10] && cnt_eff < {1'b0, l_reg.cfg_s2[9:2]})
			|=> !l_reg.line_ok && !l_reg.h_pix;
	endproperty
	a_drop_line: assert property (p_drop_line) else $error("short first line kept");

	property p_keep_line;
		@(posedge LINK_CLK) disable iff (lrst_s2)
		(line_start && (l_reg.cfg_s2[10] || setup_met)) |=> l_reg.line_ok && l_reg.h_pix;
	endproperty
	a_keep_line: assert property (p_keep_line) else $error("valid first line dropped");

	c_frame_start: cover property (@(posedge CLK) disable iff (RST)
		TX_PKT_START && TX_DATA[5:0] == DT_FRAME_START);
	c_long_done: cover property (@(posedge CLK) disable iff (RST) TX_PKT_END && hk_long);
	c_line_dropped: cover property (@(posedge LINK_CLK) disable iff (lrst_s2)
		line_start && !start_ok);
	c_short_kept: cover property (@(posedge LINK_CLK) disable iff (lrst_s2)
		line_start && !first_eff && !setup_met && l_reg.cfg_s2[10]);

endmodule : rvfcp_top

// ### testbench/rvfcp_csi2_rx.sv
/*
 * CSI-2 receiver model: rebuilds packets, checks header ECC and payload CRC.
 * Assumes a byte stream synchronous to CLK, reset together with the bench.
 */
`timescale 1ns/100ps
module rvfcp_csi2_rx (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	input wire logic TX_PKT_START,
	input wire logic TX_PKT_END
);
	localparam logic [23:0] ecc_masks [6] = '{24'hf12cb7, 24'hf2555b, 24'h749a6d,
		24'hb8e38e, 24'hdf03f0, 24'heffc00};
	logic [7:0] buf_q[$];
	logic [23:0] hdr_q[$];
	logic ok_q[$];
	logic [7:0] pay_q[$];
	logic in_pkt = 1'b0;
	int errs = 0;

	task automatic take();
		int n;
		logic ok;
		logic [15:0] crc;
		logic [23:0] hdr;
		logic [7:0] ecc;
		n = buf_q.size();
		crc = 16'hffff;
		hdr = {buf_q[2], buf_q[1], buf_q[0]};
		ecc = 8'h00;
		for (int i = 0; i < 6; i++)
			ecc[i] = ^(hdr & ecc_masks[i]);
		ok = n >= 4 && buf_q[3] === ecc;
		if (hdr[5:0] <= 6'h0f)
			ok = ok && n == 4;
		else
		begin
			ok = ok && n == hdr[23:8] + 6;
			for (int i = 4; i < n - 2; i++)
			begin
				pay_q.push_back(buf_q[i]);
				for (int b = 0; b < 8; b++)
					crc = (crc >> 1) ^ (crc[0] ^ buf_q[i][b] ? 16'h8408 : 16'h0000);
			end
			ok = ok && {buf_q[n - 1], buf_q[n - 2]} === crc;
		end
		hdr_q.push_back(hdr);
		ok_q.push_back(ok);
	endtask : take

	// A packet is one unbroken run of VALID from START to END
	always @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			buf_q.delete();
			in_pkt = 1'b0;
		end
		else if (TX_VALID)
		begin
			errs += (TX_PKT_START == in_pkt);
			if (TX_PKT_START)
				buf_q.delete();
			buf_q.push_back(TX_DATA);
			in_pkt = !TX_PKT_END;
			if (TX_PKT_END)
				take();
		end
		else
			errs += in_pkt | TX_PKT_START | TX_PKT_END;
	end
endmodule : rvfcp_csi2_rx

// ### testbench/testbench.sv
/*
 * Self-checking bench for rvfcp_top: raw frames in on the link side, packets
 * judged through the receiver model.
 * Assumes rvfcp_pkg and rvfcp_csi2_rx are compiled first.
 */
`timescale 1ns/100ps
module testbench;
	import rvfcp_pkg::*;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic fv_pin = 1'b0;
	logic lv_pin = 1'b0;
	logic [7:0] pix = 8'h00;
	logic [7:0] pol_cfg = 8'h00;
	logic [7:0] min_time = 8'h08;
	logic keep = 1'b0;
	logic [1:0] vc = 2'h0;
	logic [5:0] dt = 6'h2a;
	logic [7:0] tx_data;
	logic tx_valid;
	logic tx_start;
	logic tx_end;
	int fails = 0;
	int checked = 0;
	// Polarity, channel, type, min setup, keep, setup k, bytes, first line kept
	int rows [4][8] = '{'{0, 0, 'h2a, 8, 0, 8, 1, 1}, '{1, 1, 'h10, 0, 0, 0, 256, 1},
		'{2, 2, 'h3f, 3, 0, 4, 3, 1}, '{3, 3, 'h1e, 'h80, 0, 128, 5, 1}};

	initial
	begin
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		#7;
		forever #62.5 link_clk = ~link_clk;
	end

	rvfcp_top #(.PORT_ID(0)) i_dut (.CLK(clk), .RST(rst), .LINK_CLK(link_clk),
		.FRAME_VALID_IND(fv_pin), .LINE_VALID_IND(lv_pin), .PIXEL_DATA(pix),
		.SYNC_POLARITY_CFG(pol_cfg), .MIN_FRAME_SETUP_TIME(min_time),
		.KEEP_SHORT_FIRST_LINE(keep), .VIRTUAL_CHANNEL(vc), .LONG_DATA_TYPE(dt),
		.TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_PKT_START(tx_start),
		.TX_PKT_END(tx_end));
	rvfcp_csi2_rx i_rx (.CLK(clk), .RST(rst), .TX_DATA(tx_data), .TX_VALID(tx_valid),
		.TX_PKT_START(tx_start), .TX_PKT_END(tx_end));

	task automatic check(string what, logic [23:0] exp, logic [23:0] got);
		checked++;
		if (exp !== got)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks made %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	// Link inputs move 2 ns after a link edge
	task automatic lclk(int n);
		repeat (n) @(posedge link_clk);
		#2;
	endtask : lclk

	task automatic frame(int k, int n);
		fv_pin = ~pol_cfg[0];
		lclk(k);
		for (int l = 0; l < 2; l++)
		begin
			lv_pin = ~pol_cfg[1];
			for (int i = 0; i < n; i++)
			begin
				pix = 8'(i + 7 * l);
				lclk(1);
			end
			lv_pin = pol_cfg[1];
			// Blanking long enough for the queued line to drain
			lclk(n / 4 + 8);
		end
		fv_pin = pol_cfg[0];
	endtask : frame

	task automatic exp_pkt(logic [5:0] code, logic [15:0] wc);
		check("header", {wc, vc, code}, i_rx.hdr_q.pop_front());
		check("ecc and crc", 24'h000001, 24'(i_rx.ok_q.pop_front()));
	endtask : exp_pkt

	task automatic run_case(int r [8]);
		lclk(1);
		pol_cfg = {{3{~r[0][1:0]}}, r[0][1:0]};
		fv_pin = r[0][0];
		lv_pin = r[0][1];
		min_time = r[3][7:0];
		keep = r[4][0];
		vc = r[1][1:0];
		dt = r[2][5:0];
		// A polarity change can fake a frame; let it drain, then forget it
		lclk(12);
		i_rx.hdr_q.delete();
		i_rx.ok_q.delete();
		i_rx.pay_q.delete();
		frame(r[5], r[6]);
		for (int t = 0; t < 4000 && i_rx.hdr_q.size() < 5 + 3 * r[7]; t++)
			@(posedge clk);
		repeat (40) @(posedge clk);
		check("packet count", 24'(5 + 3 * r[7]), 24'(i_rx.hdr_q.size()));
		if (i_rx.hdr_q.size() != 5 + 3 * r[7])
			give_verdict();
		exp_pkt(DT_FRAME_START, 16'h0000);
		for (int l = 1 - r[7]; l < 2; l++)
		begin
			exp_pkt(DT_LINE_START, 16'h0000);
			exp_pkt(dt, r[6][15:0]);
			for (int i = 0; i < r[6]; i++)
				check("payload", 24'((i + 7 * l) % 256), 24'(i_rx.pay_q.pop_front()));
			exp_pkt(DT_LINE_END, 16'h0000);
		end
		exp_pkt(DT_FRAME_END, 16'h0000);
	endtask : run_case

	initial
	begin
		repeat (2) @(posedge clk);
		check("idle", 24'h000000, 24'({tx_valid, tx_start, tx_end, tx_data}));
		repeat (2) @(posedge clk);
		#2;
		rst = 1'b0;
		for (int i = 0; i < 4; i++)
			run_case(rows[i]);
		run_case('{0, 1, 'h2c, 8, 0, 7, 4, 0});
		run_case('{3, 2, 'h2c, 8, 1, 7, 4, 1});
		// Reset in the middle of a packet must silence the output at once
		fork
			begin
				// Keep link inputs moving just after a link edge
				lclk(1);
				frame(8, 64);
			end
			begin
				for (int t = 0; t < 4000 && tx_valid !== 1'b1; t++)
					@(posedge clk);
				check("packet under way", 24'h000001, 24'(tx_valid));
				if (fails > 0)
					give_verdict();
				#2;
				rst = 1'b1;
				#1;
				check("idle", 24'h000000, 24'({tx_valid, tx_start, tx_end, tx_data}));
				repeat (12) @(posedge clk);
				#2;
				rst = 1'b0;
			end
		join
		run_case(rows[0]);
		check("receiver framing errors", 24'h000000, 24'(i_rx.errs));
		give_verdict();
	end
endmodule : testbench
